// ==== design/usd_data_port.sv ====
// uart receive/transmit data location with its mode, status and interrupt registers
// assumes character-level receivers and a transmit shifter on ref_clk around it
//
// Overview of operation
// - the data location decodes as an alias of receive buffer and transmit holding
// - reads of bits 7:0 give the character from the serial or infrared receiver
// - read data is valid only while the data-ready flag in line status is set
// - fifo off: a new character overwrites an unread one and flags overrun
// - fifo on: a read returns and pops the receive fifo head
// - full receive fifo: new character dropped, contents kept, overrun flagged
// - writes of bits 7:0 queue a character for the serial or infrared transmitter
// - fifo off: a write with holding-empty set clears holding-empty
// - fifo off: further writes before holding-empty returns replace the held character
// - fifo on: writes are accepted until the transmit fifo, depth FIFO_DEPTH (16 by default), is full
// - a write while the transmit fifo is full is dropped, contents unchanged
`timescale 1ns/100ps
`include "usd_defines.svh"

module usd_data_port #(
   parameter int FIFO_DEPTH = `USD_FIFO_DEPTH
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   input  wire logic                 ce,
   input  wire usd_pkg::usd_wb_req_s wbReq,
   output logic                      wbAck,
   output logic [31:0]               wbDatO,
   input  wire usd_pkg::usd_char_s   rxSerChar,
   input  wire usd_pkg::usd_char_s   rxIrChar,
   output usd_pkg::usd_char_s        txSerChar,
   output usd_pkg::usd_char_s        txIrChar,
   input  wire logic                 txTake,
   output logic                      irMode,
   output logic                      irq
);

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("usd_data_port needs FIFO_DEPTH >= 2");
   end

   usd_pkg::usd_port_state_s st_r;
   usd_pkg::usd_port_state_s st_nxt;

   logic                   req;
   logic                   shadowRd;
   logic                   shadowWr;
   logic                   ctrlWr;
   logic                   modeChange;
   usd_pkg::usd_char_s     rxSel;
   logic                   rxOvr;
   logic                   dataReady;
   logic                   holdEmpty;
   logic                   txAvail;
   logic [`USD_CHAR_W-1:0] txSrcData;
   logic                   txLoad;
   logic [31:0]            rdMux;
   usd_pkg::usd_ev_t       ev;
   usd_pkg::usd_ev_t       w1c;
   logic [`USD_CHAR_W-1:0] rxHead;
   logic                   rxFull;
   logic                   rxEmpty;
   logic [`USD_CHAR_W-1:0] txHead;
   logic                   txFull;
   logic                   txEmpty;

   function automatic logic adrHit(input logic [31:0] a, input logic [31:0] o);
      return a[31:2] == o[31:2];
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // ack comes one edge after the request, so each access costs two cycles
   assign req      = wbReq.cyc && wbReq.stb && !st_r.ack;
   assign shadowRd = req && !wbReq.we && adrHit(wbReq.adr, `USD_ADR_SHADOW);
   assign shadowWr = req && wbReq.we && wbReq.sel[0]
                     && adrHit(wbReq.adr, `USD_ADR_SHADOW);
   assign ctrlWr   = req && wbReq.we && wbReq.sel[0] && adrHit(wbReq.adr, `USD_ADR_CTRL);
   // switching fifo mode flushes both fifos; the hold registers keep any stale byte
   assign modeChange = ctrlWr && (wbReq.dat[`USD_CTRL_FIFO_EN] != st_r.fifoEn);

   // ------------------------------------------------------------
   // receive path
   // ------------------------------------------------------------
   assign rxSel = st_r.irMode ? rxIrChar : rxSerChar;
   assign rxOvr = rxSel.valid && (st_r.fifoEn ? rxFull : st_r.rxHoldValid);
   assign dataReady = st_r.fifoEn ? !rxEmpty : st_r.rxHoldValid;

   usd_fifo #(
      .WIDTH (`USD_CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .clear    (modeChange),
      .push     (st_r.fifoEn && rxSel.valid),
      .pop      (st_r.fifoEn && shadowRd),
      .pushData (rxSel.data),
      .headData (rxHead),
      .full     (rxFull),
      .empty    (rxEmpty)
   );

   // ------------------------------------------------------------
   // transmit path
   // ------------------------------------------------------------
   assign holdEmpty = st_r.fifoEn ? txEmpty : !st_r.txHoldFull;
   assign txAvail   = st_r.fifoEn ? !txEmpty : st_r.txHoldFull;
   assign txSrcData = st_r.fifoEn ? txHead : st_r.txHold;
   // the shifter register is refilled in the cycle it is taken, no bubble
   assign txLoad    = txAvail && (!(st_r.txSer.valid || st_r.txIr.valid) || txTake);

   usd_fifo #(
      .WIDTH (`USD_CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .clear    (modeChange),
      .push     (st_r.fifoEn && shadowWr),
      .pop      (st_r.fifoEn && txLoad),
      .pushData (wbReq.dat[`USD_CHAR_W-1:0]),
      .headData (txHead),
      .full     (txFull),
      .empty    (txEmpty)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      rdMux = '0;
      if (adrHit(wbReq.adr, `USD_ADR_SHADOW)) begin
         // upper bits stay zero
         rdMux[`USD_CHAR_W-1:0] = st_r.fifoEn ? rxHead : st_r.rxHold;
      end else if (adrHit(wbReq.adr, `USD_ADR_CTRL)) begin
         rdMux[`USD_CTRL_FIFO_EN] = st_r.fifoEn;
         rdMux[`USD_CTRL_IR_MODE] = st_r.irMode;
      end else if (adrHit(wbReq.adr, `USD_ADR_LSTAT)) begin
         rdMux[`USD_LST_RDY] = dataReady;
         rdMux[`USD_LST_OVR] = st_r.overrun;
         rdMux[`USD_LST_TXE] = holdEmpty;
      end else if (adrHit(wbReq.adr, `USD_ADR_IST)) begin
         rdMux[2:0] = st_r.ist;
      end else if (adrHit(wbReq.adr, `USD_ADR_IMSK)) begin
         rdMux[2:0] = st_r.imsk;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt       = st_r;
      st_nxt.ack   = req;
      st_nxt.rdata = (req && !wbReq.we) ? rdMux : '0;

      if (ctrlWr) begin
         st_nxt.fifoEn = wbReq.dat[`USD_CTRL_FIFO_EN];
         st_nxt.irMode = wbReq.dat[`USD_CTRL_IR_MODE];
      end

      // hold-register receive: arrival beats a same-cycle read
      if (!st_r.fifoEn && shadowRd) begin
         st_nxt.rxHoldValid = 1'b0;
      end
      if (!st_r.fifoEn && rxSel.valid) begin
         st_nxt.rxHold      = rxSel.data;
         st_nxt.rxHoldValid = 1'b1;
      end

      // hold-register transmit: a late write replaces the held byte
      if (!st_r.fifoEn && txLoad) begin
         st_nxt.txHoldFull = 1'b0;
      end
      if (!st_r.fifoEn && shadowWr) begin
         st_nxt.txHold     = wbReq.dat[`USD_CHAR_W-1:0];
         st_nxt.txHoldFull = 1'b1;
      end

      // shifter hand-off, only the line selected at load time shows valid
      if (txTake) begin
         st_nxt.txSer.valid = 1'b0;
         st_nxt.txIr.valid  = 1'b0;
      end
      if (txLoad) begin
         if (st_r.irMode) begin
            st_nxt.txIr.valid = 1'b1;
            st_nxt.txIr.data  = txSrcData;
         end else begin
            st_nxt.txSer.valid = 1'b1;
            st_nxt.txSer.data  = txSrcData;
         end
      end

      // line-status overrun clears on a status read, a new overrun wins
      if (req && !wbReq.we && adrHit(wbReq.adr, `USD_ADR_LSTAT)) begin
         st_nxt.overrun = 1'b0;
      end
      if (rxOvr) begin
         st_nxt.overrun = 1'b1;
      end

      // interrupt events, write one to clear, set beats clear
      ev                = '0;
      ev[`USD_EV_RX]    = rxSel.valid;
      ev[`USD_EV_OVR]   = rxOvr;
      ev[`USD_EV_TXE]   = holdEmpty && !st_r.holdEmptyPrev;
      st_nxt.holdEmptyPrev = holdEmpty;
      w1c = (req && wbReq.we && wbReq.sel[0] && adrHit(wbReq.adr, `USD_ADR_IST))
            ? wbReq.dat[2:0] : '0;
      st_nxt.ist = (st_r.ist & ~w1c) | ev;
      if (req && wbReq.we && wbReq.sel[0] && adrHit(wbReq.adr, `USD_ADR_IMSK)) begin
         st_nxt.imsk = wbReq.dat[2:0];
      end
      st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r          <= '0;
         st_r.imsk     <= `USD_IMSK_RST;
         st_r.holdEmptyPrev <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign wbAck     = st_r.ack;
   assign wbDatO    = st_r.rdata;
   assign txSerChar = st_r.txSer;
   assign txIrChar  = st_r.txIr;
   assign irMode    = st_r.irMode;
   assign irq       = st_r.irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   property p_alias_ack;
      ce && wbReq.cyc && wbReq.stb && !wbAck |=> wbAck ##1 (!ce || !wbAck);
   endproperty
   a_alias_ack: assert property (p_alias_ack) else $error("ack not one cycle");

   property p_rx_select;
      ce && !st_r.fifoEn && st_r.irMode && rxIrChar.valid
      |=> st_r.rxHold == $past(rxIrChar.data);
   endproperty
   a_rx_select: assert property (p_rx_select) else $error("rx source wrong");

   property p_ready_after_rx;
      ce && rxSel.valid && !modeChange |=> dataReady;
   endproperty
   a_ready_after_rx: assert property (p_ready_after_rx) else $error("no data ready");

   property p_hold_overrun;
      ce && !st_r.fifoEn && rxSel.valid && st_r.rxHoldValid
      |=> st_r.overrun && st_r.ist[`USD_EV_OVR] && st_r.rxHold == $past(rxSel.data);
   endproperty
   a_hold_overrun: assert property (p_hold_overrun) else $error("overwrite lost");

   property p_fifo_read;
      ce && st_r.fifoEn && shadowRd && !rxEmpty |=> wbDatO[7:0] == $past(rxHead);
   endproperty
   a_fifo_read: assert property (p_fifo_read) else $error("fifo head wrong");

   property p_rx_full_drop;
      ce && st_r.fifoEn && rxSel.valid && rxFull && !shadowRd && !modeChange
      |=> rxFull && rxHead == $past(rxHead) && st_r.ist[`USD_EV_OVR];
   endproperty
   a_rx_full_drop: assert property (p_rx_full_drop) else $error("full fifo changed");

   property p_tx_line;
      ce && txLoad && st_r.irMode |=> txIrChar.valid && !txSerChar.valid;
   endproperty
   a_tx_line: assert property (p_tx_line) else $error("tx line wrong");

   property p_hold_empty_clear;
      ce && !st_r.fifoEn && shadowWr && !ctrlWr |=> !holdEmpty;
   endproperty
   a_hold_empty_clear: assert property (p_hold_empty_clear) else $error("holding empty stuck");

   property p_hold_replace;
      ce && !st_r.fifoEn && shadowWr |=> st_r.txHold == $past(wbReq.dat[7:0]);
   endproperty
   a_hold_replace: assert property (p_hold_replace) else $error("hold not replaced");

   property p_tx_accept;
      ce && st_r.fifoEn && shadowWr && !txFull && !modeChange |=> !txEmpty;
   endproperty
   a_tx_accept: assert property (p_tx_accept) else $error("tx write lost");

   property p_tx_full_drop;
      ce && st_r.fifoEn && shadowWr && txFull && !txLoad && !modeChange
      |=> txFull && txHead == $past(txHead);
   endproperty
   a_tx_full_drop: assert property (p_tx_full_drop) else $error("full tx changed");

   property p_reserved_zero;
      ce && shadowRd |=> wbDatO[31:8] == 24'h000000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero");

   c_rx_overrun: cover property (ce && st_r.fifoEn && rxOvr);
   c_tx_full:    cover property (ce && st_r.fifoEn && shadowWr && txFull);
   c_irq_rise:   cover property (ce && !irq ##1 irq);
   c_ir_tx:      cover property (ce && txLoad && st_r.irMode);

endmodule

// ==== design/usd_defines.svh ====
// offsets, field positions, reset values and sizes of the uart data port
// assumes a 32-bit classic wishbone address space with word-aligned registers
`ifndef USD_DEFINES_SVH
`define USD_DEFINES_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define USD_ADR_SHADOW  32'h5000_1060
`define USD_ADR_CTRL    32'h5000_1100
`define USD_ADR_LSTAT   32'h5000_1104
`define USD_ADR_IST     32'h5000_1108
`define USD_ADR_IMSK    32'h5000_110c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define USD_CTRL_FIFO_EN 0
`define USD_CTRL_IR_MODE 1
`define USD_LST_RDY      0
`define USD_LST_OVR      1
`define USD_LST_TXE      5
`define USD_EV_RX        0
`define USD_EV_OVR       1
`define USD_EV_TXE       2

// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define USD_SHADOW_RST   16'h0000
`define USD_IMSK_RST     3'h0
`define USD_FIFO_DEPTH   16
`define USD_CHAR_W       8

`endif

// ==== design/usd_pkg.sv ====
// types shared by the uart data port and its testbench
// assumes usd_defines.svh is on the include path
`include "usd_defines.svh"

package usd_pkg;

   // classic wishbone request as driven by the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } usd_wb_req_s;

   // one character with its strobe or valid flag
   typedef struct packed {
      logic                    valid;
      logic [`USD_CHAR_W-1:0]  data;
   } usd_char_s;

   typedef logic [2:0] usd_ev_t;

   // state of the data port outside its two fifos
   typedef struct packed {
      logic                    ack;
      logic [31:0]             rdata;
      logic                    fifoEn;
      logic                    irMode;
      logic [`USD_CHAR_W-1:0]  rxHold;
      logic                    rxHoldValid;
      logic [`USD_CHAR_W-1:0]  txHold;
      logic                    txHoldFull;
      usd_char_s               txSer;
      usd_char_s               txIr;
      logic                    overrun;
      logic                    holdEmptyPrev;
      usd_ev_t                 ist;
      usd_ev_t                 imsk;
      logic                    irq;
   } usd_port_state_s;

endpackage

// ==== design/usd_fifo.sv ====
// character fifo used for both the receive and the transmit direction
// assumes push and pop come from logic on ref_clk; pushes while full are dropped
`timescale 1ns/100ps
`include "usd_defines.svh"

module usd_fifo #(
   parameter int WIDTH = `USD_CHAR_W,
   parameter int DEPTH = `USD_FIFO_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   input  wire logic             clear,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] pushData,
   output logic      [WIDTH-1:0] headData,
   output logic                  full,
   output logic                  empty
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("usd_fifo needs DEPTH >= 2 and WIDTH >= 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rdPtr;
      logic [AW-1:0]               wrPtr;
      logic [CW-1:0]               count;
   } usd_fifo_state_s;

   usd_fifo_state_s st_r;
   usd_fifo_state_s st_nxt;
   logic            doPush;
   logic            doPop;

   function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign full     = (st_r.count == CW'(DEPTH));
   assign empty    = (st_r.count == '0);
   assign headData = st_r.mem[st_r.rdPtr];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      doPush = push && !full;   // full fifo keeps its contents
      doPop  = pop && !empty;
      if (doPush) begin
         st_nxt.mem[st_r.wrPtr] = pushData;
         st_nxt.wrPtr           = ptrInc(st_r.wrPtr);
      end
      if (doPop) begin
         st_nxt.rdPtr = ptrInc(st_r.rdPtr);
      end
      if (doPush && !doPop) begin
         st_nxt.count = st_r.count + CW'(1);
      end else if (doPop && !doPush) begin
         st_nxt.count = st_r.count - CW'(1);
      end
      if (clear) begin
         st_nxt.rdPtr = '0;
         st_nxt.wrPtr = '0;
         st_nxt.count = '0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

endmodule

// ==== testbench/usd_line_model.sv ====
// far-side peer of the uart data port: character receiver source and transmit shifter
// assumes the bench commands each received character and when the shifter stalls
`timescale 1ns/100ps

module usd_line_model (
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   input  wire logic               irMode,
   input  wire logic               sendReq,
   input  wire logic [7:0]         sendData,
   input  wire logic               stall,
   input  wire usd_pkg::usd_char_s txSerChar,
   input  wire usd_pkg::usd_char_s txIrChar,
   output usd_pkg::usd_char_s      rxSerChar,
   output usd_pkg::usd_char_s      rxIrChar,
   output logic                    txTake
);
   // bit 8 marks a character that left on the infrared line
   logic [8:0] gotQ[$];

   // ------------------------------------------------------------
   // line behaviour
   // ------------------------------------------------------------
   // idle data toggles each cycle so a stale character can never pass for a new one
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxSerChar <= '0;
         rxIrChar <= '0;
         txTake <= 1'b0;
      end else begin
         rxSerChar.valid <= sendReq && !irMode;
         rxIrChar.valid <= sendReq && irMode;
         rxSerChar.data <= (sendReq && !irMode) ? sendData : ~rxSerChar.data;
         rxIrChar.data <= (sendReq && irMode) ? sendData : ~rxIrChar.data;
         txTake <= 1'b0;
         if (!stall && !txTake && (txSerChar.valid || txIrChar.valid)) begin
            txTake <= 1'b1;
            gotQ.push_back(txIrChar.valid ? {1'b1, txIrChar.data} : {1'b0, txSerChar.data});
         end
      end
   end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench of the uart data port with a queue model of its buffers
// assumes the line model stands at the far side; registers reached over wishbone
`timescale 1ns/100ps
`include "usd_defines.svh"

module tb;
   localparam int DEPTH = 4;
   logic                 ref_clk;
   logic                 rst_b;
   usd_pkg::usd_wb_req_s wbReq;
   logic                 wbAck;
   logic [31:0]          wbDatO;
   usd_pkg::usd_char_s   rxSerChar;
   usd_pkg::usd_char_s   rxIrChar;
   usd_pkg::usd_char_s   txSerChar;
   usd_pkg::usd_char_s   txIrChar;
   logic                 txTake;
   logic                 irMode;
   logic                 irq;
   logic                 sendReq;
   logic [7:0]           sendData;
   logic                 stall;
   int                   num_errors;
   int                   tests_run;
   int                   seed;
   logic [31:0]          rd;
   logic [7:0]           d;
   logic [7:0]           rxExp[$];
   logic [8:0]           txExp[$];

   usd_data_port #(.FIFO_DEPTH(DEPTH)) usd_data_port_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .ce(1'b1), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO), .rxSerChar(rxSerChar),
      .rxIrChar(rxIrChar), .txSerChar(txSerChar), .txIrChar(txIrChar), .txTake(txTake),
      .irMode(irMode), .irq(irq));

   usd_line_model usd_line_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .irMode(irMode),
      .sendReq(sendReq), .sendData(sendData), .stall(stall), .txSerChar(txSerChar),
      .txIrChar(txIrChar), .rxSerChar(rxSerChar), .rxIrChar(rxIrChar), .txTake(txTake));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one classic cycle; the request holds until ack is sampled at a rising edge
   task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge ref_clk);
      wbReq <= {1'b1, 1'b1, we, 4'h1, adr, dat};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      if (n >= 50)
         check(32'h0, 32'h1);
      rd = wbDatO;
      wbReq <= '0;
   endtask

   task automatic send(input logic [7:0] c);
      @(posedge ref_clk);
      sendReq <= 1'b1;
      sendData <= c;
      @(posedge ref_clk);
      sendReq <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic check_tx();
      check(usd_line_model_i.gotQ.size(), txExp.size());
      foreach (txExp[i])
         if (i < usd_line_model_i.gotQ.size())
            check(usd_line_model_i.gotQ[i], txExp[i]);
      usd_line_model_i.gotQ.delete();
      txExp.delete();
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      #(20 * 20000);
      num_errors++;
      stop_test();
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      num_errors = 0;
      tests_run = 0;
      seed = 32'h81bcc627;
      rst_b = 1'b0;
      wbReq = '0;
      sendReq = 1'b0;
      sendData = 8'h00;
      stall = 1'b0;
      wait_clk(4);
      rst_b <= 1'b1;
      wb(0, `USD_ADR_SHADOW, 0);
      check(rd, 32'h0);
      wb(0, 32'h5000_1200, 0);
      check(rd, 32'h0);
      // hold mode receive, interrupt raise, mask and clear
      wb(1, `USD_ADR_IST, 32'h7);
      wb(1, `USD_ADR_IMSK, 32'h1);
      d = $random(seed);
      send(d);
      wait_clk(2);
      check(irq, 1'b1);
      wb(0, `USD_ADR_LSTAT, 0);
      check(rd, 32'h21);
      wb(0, `USD_ADR_SHADOW, 0);
      check(rd, {24'h0, d});
      wb(1, `USD_ADR_IMSK, 32'h0);
      wait_clk(2);
      check(irq, 1'b0);
      wb(0, `USD_ADR_IST, 0);
      check(rd & 32'h1, 32'h1);
      wb(1, `USD_ADR_IST, 32'h1);
      wb(0, `USD_ADR_IST, 0);
      check(rd & 32'h1, 32'h0);
      send($random(seed));
      d = $random(seed);
      send(d);
      wb(0, `USD_ADR_LSTAT, 0);
      check(rd, 32'h23);
      wb(0, `USD_ADR_SHADOW, 0);
      check(rd, {24'h0, d});
      wb(0, `USD_ADR_LSTAT, 0);
      check(rd, 32'h20);
      // hold mode transmit with the shifter stalled
      stall <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         d = $random(seed);
         wb(0, `USD_ADR_LSTAT, 0);
         check(rd & 32'h20, (i == 2) ? 32'h0 : 32'h20);
         wb(1, `USD_ADR_SHADOW, {24'hffffff, d});
         if (i != 1)
            txExp.push_back({1'b0, d});
         wait_clk(3);
      end
      stall <= 1'b0;
      wait_clk(10);
      check_tx();
      wb(0, `USD_ADR_IST, 0);
      check(rd & 32'h4, 32'h4);
      // infrared mode in both directions
      wb(1, `USD_ADR_CTRL, 32'h2);
      check(irMode, 1'b1);
      d = $random(seed);
      send(d);
      wb(0, `USD_ADR_SHADOW, 0);
      check(rd, {24'h0, d});
      wb(1, `USD_ADR_SHADOW, {24'h0, ~d});
      txExp.push_back({1'b1, ~d});
      wait_clk(6);
      check_tx();
      // fifo mode: fill past full both ways, then drain
      wb(1, `USD_ADR_CTRL, 32'h1);
      for (int i = 0; i <= DEPTH; i++) begin
         d = $random(seed);
         if (i < DEPTH)
            rxExp.push_back(d);
         send(d);
      end
      wb(0, `USD_ADR_LSTAT, 0);
      check(rd & 32'h3, 32'h3);
      for (int i = 0; i < DEPTH; i++) begin
         wb(0, `USD_ADR_SHADOW, 0);
         check(rd, {24'h0, rxExp.pop_front()});
      end
      wb(0, `USD_ADR_LSTAT, 0);
      check(rd & 32'h1, 32'h0);
      stall <= 1'b1;
      for (int i = 0; i < DEPTH + 3; i++) begin
         d = $random(seed);
         wb(1, `USD_ADR_SHADOW, {24'h0, d});
         if (i <= DEPTH)
            txExp.push_back({1'b0, d});
      end
      stall <= 1'b0;
      wait_clk(3 * (DEPTH + 4));
      check_tx();
      stop_test();
   end
endmodule
